// file: design/card_port_ctrl.sv
// Control-signal logic of a flash card parallel host port: reset sequencing,
// mode selection, cycle extension / ready / data-out strobe, write strobe
// capture and the write-protect / 16-bit indication pin.
// Assumes the card core drives the status inputs on clk_sys and that the
// host pins are asynchronous to it.
`timescale 1ns/1ps
module card_port_ctrl #(
    parameter int DATA_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              ce,
    input  wire logic              reset_pin,
    input  wire logic              oe_n_pin,
    input  wire logic              we_n_pin,
    input  wire logic              reg_n_pin,
    input  wire logic [DATA_W-1:0] data_pin,
    input  wire logic              soft_reset,
    input  wire logic              io_config,
    input  wire logic              host_cycle,
    input  wire logic              core_busy,
    input  wire logic              udma_write,
    input  wire logic              udma_read,
    input  wire logic              udma_pause,
    input  wire logic              dstrobe_step,
    input  wire logic              word_xfer,
    input  wire logic              io16_port,
    output logic                   card_reset,
    output logic                   mode_ata,
    output logic                   wait_pin,
    output logic                   wait_oe_n,
    output logic                   wp_pin,
    output logic                   task_wr,
    output logic                   cfg_wr,
    output logic [DATA_W-1:0]      wr_data
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    localparam int SYNC_W = card_port_pkg::CTRL_W + DATA_W;
    localparam logic [card_port_pkg::RST_CNT_W-1:0] CNT_LOAD =
        card_port_pkg::RST_CNT_W'(card_port_pkg::INIT_RESET_CYC - 1);

    if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
        $error("DATA_W must lie between 1 and 16");
    end
    if (card_port_pkg::INIT_RESET_CYC >= (1 << card_port_pkg::RST_CNT_W)) begin : g_bad_cnt
        $error("Reset length does not fit the counter");
    end

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    sync_if #(.W(SYNC_W)) pins ();

    assign pins.raw = {data_pin, reg_n_pin, we_n_pin, oe_n_pin, reset_pin};

    pin_sync #(.W(SYNC_W)) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .port    (pins)
    );

    logic              rst_s;
    logic              oe_s;
    logic              we_s;
    logic              reg_s;
    logic [DATA_W-1:0] data_s;

    assign rst_s  = pins.synced[card_port_pkg::PIN_RESET];
    assign oe_s   = pins.synced[card_port_pkg::PIN_OE_N];
    assign we_s   = pins.synced[card_port_pkg::PIN_WE_N];
    assign reg_s  = pins.synced[card_port_pkg::PIN_REG_N];
    assign data_s = pins.synced[SYNC_W-1:card_port_pkg::CTRL_W];

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    card_port_pkg::rst_state_t             state;
    card_port_pkg::rst_state_t             next_state;
    logic [card_port_pkg::RST_CNT_W-1:0]   cnt;
    logic [card_port_pkg::RST_CNT_W-1:0]   next_cnt;
    logic                                  armed;
    logic                                  next_armed;
    logic                                  next_mode_ata;
    logic                                  next_card_reset;
    logic                                  hw_rst;
    logic                                  running;

    // Pin polarity follows the latched mode; PC reset needs a low seen first
    assign hw_rst  = mode_ata ? ~rst_s : (rst_s & armed);
    assign running = (state == card_port_pkg::ST_RUN);

    // Next state of the sequencer
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_armed    = armed;
        next_mode_ata = mode_ata;
        // A pin open or high since power-up never arms the reset input
        if (state != card_port_pkg::ST_INIT && !rst_s) begin
            next_armed = 1'b1;
        end
        case (state)
            card_port_pkg::ST_INIT: begin
                // Mode pin is stable throughout the power-up reset
                next_mode_ata = ~oe_s;
                if (cnt == '0) begin
                    next_state = card_port_pkg::ST_RUN;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            card_port_pkg::ST_RUN: begin
                if (hw_rst || soft_reset) begin
                    next_state = card_port_pkg::ST_RESET;
                    next_cnt   = CNT_LOAD;
                end
            end
            card_port_pkg::ST_RESET: begin
                // Held while the cause stands, then a fixed tail
                if (hw_rst || soft_reset) begin
                    next_cnt = CNT_LOAD;
                end else if (cnt == '0) begin
                    next_state = card_port_pkg::ST_RUN;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = card_port_pkg::ST_INIT;
                next_cnt   = CNT_LOAD;
            end
        endcase
        next_card_reset = (next_state != card_port_pkg::ST_RUN);
        if (!ce) begin
            next_state      = state;
            next_cnt        = cnt;
            next_armed      = armed;
            next_mode_ata   = mode_ata;
            next_card_reset = card_reset;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state      <= card_port_pkg::ST_INIT;
            cnt        <= CNT_LOAD;
            armed      <= 1'b0;
            mode_ata   <= 1'b0;
            card_reset <= 1'b1;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            armed      <= next_armed;
            mode_ata   <= next_mode_ata;
            card_reset <= next_card_reset;
        end
    end

    // ****************************************************************
    // Write strobe capture
    // ****************************************************************
    logic              we_prev;
    logic              next_we_prev;
    logic              we_rise;
    logic              next_task_wr;
    logic              next_cfg_wr;
    logic [DATA_W-1:0] next_wr_data;

    // End of the active-low strobe; data is still held by the host there
    assign we_rise = we_s & ~we_prev;

    // Decode of a finished host write
    always_comb begin
        next_we_prev = we_s;
        next_task_wr = 1'b0;
        next_cfg_wr  = 1'b0;
        next_wr_data = wr_data;
        // ATA mode leaves the strobe unused, whatever level it has
        if (running && we_rise && !mode_ata) begin
            if (!reg_s) begin
                next_cfg_wr  = 1'b1;
                next_wr_data = data_s;
            end else if (!io_config) begin
                next_task_wr = 1'b1;
                next_wr_data = data_s;
            end
        end
        if (!ce) begin
            next_we_prev = we_prev;
            next_task_wr = task_wr;
            next_cfg_wr  = cfg_wr;
            next_wr_data = wr_data;
        end
    end

    // Strobe registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            we_prev <= 1'b1;
            task_wr <= 1'b0;
            cfg_wr  <= 1'b0;
            wr_data <= '0;
        end else begin
            we_prev <= next_we_prev;
            task_wr <= next_task_wr;
            cfg_wr  <= next_cfg_wr;
            wr_data <= next_wr_data;
        end
    end

    // ****************************************************************
    // Shared wait / ready / strobe pin and indication pin
    // ****************************************************************
    logic next_wait_pin;
    logic next_wait_oe_n;
    logic next_wp_pin;

    // Pin meaning depends on mode and on the Ultra DMA direction
    always_comb begin
        next_wait_oe_n = ~running;  // Released during any reset
        next_wait_pin  = 1'b1;
        next_wp_pin    = 1'b1;
        if (running) begin
            if (!mode_ata) begin
                next_wait_pin = ~(host_cycle & core_busy);
                next_wp_pin   = io_config ? ~io16_port : 1'b0;
            end else begin
                next_wp_pin = ~word_xfer;
                if (udma_write) begin
                    next_wait_pin = udma_pause;
                end else if (udma_read) begin
                    // No edge while paused; host sees a quiet strobe
                    next_wait_pin = (dstrobe_step && !udma_pause) ? ~wait_pin
                                                                  : wait_pin;
                end else begin
                    next_wait_pin = ~core_busy;
                end
            end
        end
        if (!ce) begin
            next_wait_pin  = wait_pin;
            next_wait_oe_n = wait_oe_n;
            next_wp_pin    = wp_pin;
        end
    end

    // Pin registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wait_pin  <= 1'b1;
            wait_oe_n <= 1'b1;
            wp_pin    <= 1'b1;
        end else begin
            wait_pin  <= next_wait_pin;
            wait_oe_n <= next_wait_oe_n;
            wp_pin    <= next_wp_pin;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_pc_reset_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && !mode_ata && armed && rst_s) |=> card_reset)
        else $error("PC Card reset pin high did not reset the card");

    a_init_once: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && state == card_port_pkg::ST_INIT && cnt == '0) |=> running && !card_reset)
        else $error("Initial reset did not finish");

    a_soft_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && soft_reset) |=> card_reset ##1 (card_reset || !ce))
        else $error("Soft reset bit ignored");

    a_ata_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && mode_ata && !rst_s) |=> card_reset ##1 (wait_oe_n || !$past(ce)))
        else $error("ATA reset low did not reset the card");

    a_wait_stretch: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && !mode_ata && host_cycle && core_busy) |=> !wait_pin && !wait_oe_n)
        else $error("Wait not driven low for busy cycle");

    a_iordy_ready: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && mode_ata && !udma_write && !udma_read)
            |=> wait_pin == !$past(core_busy))
        else $error("IORDY does not follow core readiness");

    a_ddmardy_pause: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && mode_ata && udma_write) |=> wait_pin == $past(udma_pause))
        else $error("DDMARDY does not reflect pause");

    a_dstrobe_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && mode_ata && !udma_write && udma_read && dstrobe_step && !udma_pause)
            |=> wait_pin != $past(wait_pin))
        else $error("Data-out strobe missed an edge");

    a_dstrobe_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && mode_ata && !udma_write && udma_read && udma_pause) |=> $stable(wait_pin))
        else $error("Data-out strobe moved while paused");

    a_task_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && !mode_ata && we_rise && reg_s && !io_config)
            |=> task_wr && wr_data == $past(data_s))
        else $error("Memory mode task write not captured");

    a_io_cfg_only: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && (io_config || mode_ata)) |=> !task_wr)
        else $error("Task write outside memory mode");

    a_wp_states: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && !mode_ata && !io_config) |=> !wp_pin)
        else $error("Write protect not low after initialisation");

    a_io16_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && !mode_ata && io_config) |=> wp_pin == !$past(io16_port))
        else $error("16-bit port flag wrong");

    a_iocs16_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
        (ce && running && mode_ata) |=> wp_pin == !$past(word_xfer))
        else $error("IOCS16 does not follow word transfer");

    a_mode_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state != card_port_pkg::ST_INIT) |=> $stable(mode_ata))
        else $error("Mode changed after power-up reset");

endmodule

// file: pkg/card_port_pkg.sv
// Constants, state codes and pin layout for the card host port control block.
// Assumes a single 10 MHz system clock; all pins arrive unsynchronised.
package card_port_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 100;
    localparam int INIT_RESET_NS  = 1000;   // Length of the power-up reset and of each reset tail
    // Least time, so round up to whole cycles
    localparam int INIT_RESET_CYC = (INIT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W      = 8;

    // ****************************************************************
    // Layout of the synchronised pin vector
    // ****************************************************************
    localparam int PIN_RESET = 0;
    localparam int PIN_OE_N  = 1;
    localparam int PIN_WE_N  = 2;
    localparam int PIN_REG_N = 3;
    localparam int CTRL_W    = 4;           // Data pins follow the control pins

    // ****************************************************************
    // Reset sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_INIT  = 3'h1,
        ST_RUN   = 3'h2,
        ST_RESET = 3'h4
    } rst_state_t;

endpackage

// file: pkg/sync_if.sv
// Carrier between the pin synchroniser and the port controller.
// Raw pin levels go in, levels retimed to clk_sys come out.
`timescale 1ns/1ps
interface sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] synced;

    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface

// file: design/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes every bit is an independent level; multi-bit words must be stable
// around the moment they are used.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic ce,
    sync_if.sync      port
);

    logic [W-1:0] meta;
    logic [W-1:0] stage2;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_stage2;

    // ****************************************************************
    // Next values; first stage feeds only the second
    // ****************************************************************
    always_comb begin
        next_meta   = ce ? port.raw : meta;
        next_stage2 = ce ? meta : stage2;
    end

    // Registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta   <= '0;
            stage2 <= '0;
        end else begin
            meta   <= next_meta;
            stage2 <= next_stage2;
        end
    end

    assign port.synced = stage2;

endmodule

// file: test/host_model.sv
// Host side model: reset, mode select, write strobe and write data pins.
// Assumes the bench clk_sys; pins change just after rising edges.
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_sys,
    input  wire logic        wait_wire,
    input  wire logic        strobe_on,
    output logic             reset_pin,
    output logic             oe_n_pin,
    output logic             we_n_pin,
    output logic             reg_n_pin,
    output logic [15:0]      data_pin,
    output int               edges
);
    logic last_strobe = 1'b1;

    initial begin
        reset_pin = 1'b1;    // Left high from power-up
        oe_n_pin  = 1'b1;    // Mode level fixed before power-up
        we_n_pin  = 1'b1;    // Idle, and tied high in ATA mode
        reg_n_pin = 1'b1;
        data_pin  = 16'h0000;
        edges     = 0;
    end

    // Host latches one word on every strobe edge, either direction
    always @(posedge clk_sys) begin
        if (strobe_on && wait_wire !== last_strobe)
            edges <= edges + 1;
        last_strobe <= wait_wire;
    end

    // ****************************************************************
    // Strobe cycles: 400 ns low, 400 ns high, an 800 ns strobe period
    // ****************************************************************
    task automatic write_word(input logic reg_n, input logic [15:0] data);
        @(posedge clk_sys);
        reg_n_pin <= reg_n;  // Attribute select picks the target
        data_pin  <= data;
        we_n_pin  <= 1'b0;
        repeat (4) @(posedge clk_sys);
        we_n_pin  <= 1'b1;
        repeat (4) @(posedge clk_sys);
        data_pin  <= ~data;  // Hold over: bus must not keep the word
    endtask

    task automatic set_level(input logic rst, input logic oe_n);
        @(posedge clk_sys);
        reset_pin <= rst;
        oe_n_pin  <= oe_n;
    endtask
endmodule

// file: test/tb_top.sv
// Bench for the card host port control block: random core status plus
// hand-picked resets, writes and strobe bursts against a host model.
// Assumes a 10 MHz clk_sys; core inputs change on its rising edges.
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys = 1'b0;
    logic        resetn, ce, soft_reset, reset_pin, oe_n_pin, we_n_pin, reg_n_pin;
    logic        io_config, host_cycle, core_busy, udma_write, udma_read;
    logic        udma_pause, dstrobe_step, word_xfer, io16_port;
    logic        card_reset, mode_ata, wait_pin, wait_oe_n, wp_pin, task_wr, cfg_wr;
    logic [8:0]  core;
    logic [15:0] data_pin, wr_data;
    int          err_total, n_compared, n_task, n_cfg, edges, e0;
    wire         wait_wire = wait_oe_n ? 1'b1 : wait_pin;  // Pull-up when released

    assign {io_config, host_cycle, core_busy, udma_write, udma_read,
            udma_pause, dstrobe_step, word_xfer, io16_port} = core;

    always #50 clk_sys = ~clk_sys;

    card_port_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .reset_pin(reset_pin), .oe_n_pin(oe_n_pin), .we_n_pin(we_n_pin),
        .reg_n_pin(reg_n_pin), .data_pin(data_pin), .soft_reset(soft_reset),
        .io_config(io_config), .host_cycle(host_cycle), .core_busy(core_busy),
        .udma_write(udma_write), .udma_read(udma_read), .udma_pause(udma_pause),
        .dstrobe_step(dstrobe_step), .word_xfer(word_xfer), .io16_port(io16_port),
        .card_reset(card_reset), .mode_ata(mode_ata), .wait_pin(wait_pin),
        .wait_oe_n(wait_oe_n), .wp_pin(wp_pin), .task_wr(task_wr), .cfg_wr(cfg_wr),
        .wr_data(wr_data));

    host_model host_u (.clk_sys(clk_sys), .wait_wire(wait_wire),
        .strobe_on(udma_read & ~udma_write), .reset_pin(reset_pin),
        .oe_n_pin(oe_n_pin), .we_n_pin(we_n_pin), .reg_n_pin(reg_n_pin),
        .data_pin(data_pin), .edges(edges));

    // Write pulses counted so a stretched pulse shows up as two
    always @(posedge clk_sys) begin
        if (task_wr === 1'b1)
            n_task <= n_task + 1;
        if (cfg_wr === 1'b1)
            n_cfg <= n_cfg + 1;
    end

    // ****************************************************************
    // Compares and expectations
    // ****************************************************************
    task automatic chk1(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    function automatic logic exp_wait(input logic ata, hc, bz, uw, ps);
        if (ata && uw)
            return ps;           // Ready negated means pause
        return !(hc && bz);      // Low only while the access cannot finish
    endfunction

    function automatic logic exp_wp(input logic ata, io, p16, wx);
        if (ata)
            return !wx;
        return io ? !p16 : 1'b0;
    endfunction

    task automatic do_write(input logic reg_n, input int et, input int ec);
        logic [15:0] d;
        int          t0;
        int          c0;
        d  = 16'($urandom);
        t0 = n_task;
        c0 = n_cfg;
        host_u.write_word(reg_n, d);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk1("task_wr count", 1'b1, (n_task - t0) == et);
        chk1("cfg_wr count", 1'b1, (n_cfg - c0) == ec);
        if (et + ec > 0)
            chk_w("wr_data", d, wr_data);
    endtask

    // Reset tail must last its full count, and not much longer
    task automatic wait_low(input int lo);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (card_reset !== 1'b0 && n < 40);
        chk1("reset tail", 1'b1, n >= lo && n <= lo + 4);
    endtask

    // Inputs launched at one edge, seen registered after the next
    task automatic rnd_phase(input logic ata, input int n);
        logic io, hc, bz, uw, ur, ps, st, wx, p16, prev, prev_rd, rd;
        prev_rd = 1'b0;
        prev    = wait_pin;
        repeat (n) begin
            {io, bz, ps, st, wx, p16} = 6'($urandom);
            hc = ata | 1'($urandom);
            uw = ata && ($urandom % 4 == 0);
            ur = ata && ($urandom % 2 == 0);
            rd = ur && !uw;
            @(posedge clk_sys);
            core <= {io, hc, bz, uw, ur, ps, st, wx, p16};
            @(posedge clk_sys);
            core[2] <= 1'b0;
            @(negedge clk_sys);
            chk1("wait_oe_n", 1'b0, wait_oe_n);
            chk1("wp_pin", exp_wp(ata, io, p16, wx), wp_pin);
            if (rd && prev_rd)
                chk1("strobe edge", st && !ps, wait_pin ^ prev);
            else if (!rd)
                chk1("wait_pin", exp_wait(ata, hc, bz, uw, ps), wait_pin);
            prev    = wait_pin;
            prev_rd = rd;
        end
    endtask

    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run is under two thousand cycles; 2 ms means a hang
    initial begin
        #2_000_000;
        err_total++;
        end_of_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h75ece476));
        {resetn, soft_reset, core, err_total, n_compared, n_task, n_cfg} = '0;
        ce = 1'b1;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (9) @(posedge clk_sys);
        @(negedge clk_sys);
        chk1("card_reset", 1'b1, card_reset);
        @(negedge clk_sys);
        chk1("card_reset", 1'b0, card_reset);
        chk1("mode_ata", 1'b0, mode_ata);
        repeat (2) @(negedge clk_sys);
        chk1("wp_pin", 1'b0, wp_pin);
        do_write(1'b1, 1, 0);
        do_write(1'b0, 0, 1);
        @(posedge clk_sys);
        core <= 9'h100;
        do_write(1'b1, 0, 0);
        do_write(1'b0, 0, 1);
        rnd_phase(1'b0, 300);
        // Pin reset only after it was seen low once
        host_u.set_level(1'b0, 1'b1);
        repeat (4) @(posedge clk_sys);
        host_u.set_level(1'b1, 1'b1);
        repeat (20) @(negedge clk_sys);
        chk1("card_reset", 1'b1, card_reset);
        chk1("wait_oe_n", 1'b1, wait_oe_n);
        do_write(1'b0, 0, 0);
        host_u.set_level(1'b0, 1'b1);
        wait_low(12);
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk1("card_reset", 1'b1, card_reset);
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        wait_low(10);
        // Second power-up with the mode pin low selects ATA
        host_u.set_level(1'b1, 1'b0);
        resetn <= 1'b0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (14) @(negedge clk_sys);
        chk1("mode_ata", 1'b1, mode_ata);
        chk1("card_reset", 1'b0, card_reset);
        do_write(1'b0, 0, 0);
        rnd_phase(1'b1, 400);
        @(posedge clk_sys);
        core <= 9'h010;
        repeat (3) @(posedge clk_sys);
        e0 = edges;
        core <= 9'h014;                                // Six back-to-back steps
        repeat (6) @(posedge clk_sys);
        core <= 9'h01C;                                // Paused steps give no edge
        repeat (3) @(posedge clk_sys);
        core <= 9'h010;
        repeat (4) @(posedge clk_sys);
        chk1("strobe edges", 1'b1, (edges - e0) == 6);
        host_u.set_level(1'b0, 1'b0);
        repeat (6) @(negedge clk_sys);
        chk1("card_reset", 1'b1, card_reset);
        host_u.set_level(1'b1, 1'b0);
        wait_low(12);
        end_of_test();
    end
endmodule
